// *** verilog/dsrh_pkg.sv ***
// shared constants and types for the address and soft-reset register pair
`default_nettype none
package dsrh_pkg;

    // ******************************************************************
    // register offsets
    // ******************************************************************
    localparam logic [7:0] DSRH_OFS_ADDR = 8'h00;
    localparam logic [7:0] DSRH_OFS_RST = 8'h01;
    localparam logic [7:0] DSRH_OFS_STS = 8'h04;

    // ******************************************************************
    // field positions
    // ******************************************************************
    localparam int DSRH_OVR_BIT = 0;
    localparam int DSRH_ADDR_LSB = 1;
    localparam int DSRH_ADDR_MSB = 7;
    localparam int DSRH_LOGIC_RST_BIT = 0;
    localparam int DSRH_FULL_RST_BIT = 1;
    localparam int DSRH_RELOAD_BIT = 2;
    localparam int DSRH_INIT_DONE_BIT = 6;

    // ******************************************************************
    // reset values
    // ******************************************************************
    localparam logic DSRH_OVR_RST = 1'b0;
    localparam logic [6:0] DSRH_SW_ADDR_RST = 7'h00;
    localparam logic [2:0] DSRH_PEND_RST = 3'h0;
    localparam logic [7:0] DSRH_PTR_RST = 8'h00;
    localparam logic [7:0] DSRH_RD_UNMAPPED = 8'h00;

    // ******************************************************************
    // timing
    // ******************************************************************
    localparam int DSRH_CLK_PERIOD_NS = 40;
    localparam int DSRH_ROM_LOAD_NS = 2000;
    localparam int DSRH_RST_PULSE_NS = 200;
    localparam int DSRH_ROM_LOAD_CYC =
        (DSRH_ROM_LOAD_NS + DSRH_CLK_PERIOD_NS - 1) / DSRH_CLK_PERIOD_NS;
    localparam int DSRH_RST_PULSE_CYC =
        (DSRH_RST_PULSE_NS + DSRH_CLK_PERIOD_NS - 1) / DSRH_CLK_PERIOD_NS;

    // ******************************************************************
    // serial target states
    // ******************************************************************
    typedef enum logic [2:0] {
        DSRH_IDLE,
        DSRH_RECV,
        DSRH_ACK_OUT,
        DSRH_SEND,
        DSRH_ACK_IN,
        DSRH_IGNORE
    } dsrh_i2c_state_type;

endpackage
`default_nettype wire

// *** verilog/dsrh_strap_sample.sv ***
// strap pin synchroniser and address capture
`default_nettype none
`timescale 1ns/10ps
module dsrh_strap_sample (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // strap pins and recapture request
    input wire logic [6:0] strap_pin,
    input wire logic recapture,
    // captured address
    output logic [6:0] strap_addr_q
);
    import dsrh_pkg::*;

    logic [6:0] meta_q;
    logic [6:0] sync_q;
    logic armed_q;
    logic armed_d;
    logic [6:0] strap_addr_d;

    // two-flop synchroniser, first stage feeds only the second
    always_ff @(posedge core_clk) begin
        meta_q <= strap_pin;
        sync_q <= meta_q;
    end

    // capture once after reset release, again on full soft reset
    always_comb begin
        armed_d = 1'b1;
        strap_addr_d = strap_addr_q;
        if (!armed_q || recapture) begin
            strap_addr_d = sync_q;
        end
    end

    // reset only loads constants; the pin level is caught after release
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
            strap_addr_q <= DSRH_SW_ADDR_RST;
        end else begin
            armed_q <= armed_d;
            strap_addr_q <= strap_addr_d;
        end
    end
endmodule // dsrh_strap_sample
`default_nettype wire

// *** verilog/dsrh_autoload.sv ***
// configuration rom auto-load sequencer
`default_nettype none
`timescale 1ns/10ps
module dsrh_autoload (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // restart request
    input wire logic restart,
    // status
    output logic busy_q,
    output logic init_done_q
);
    import dsrh_pkg::*;

    localparam logic [7:0] LOAD_CYC = 8'(DSRH_ROM_LOAD_CYC);

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic busy_d;
    logic init_done_d;

    // load starts by itself after reset, or on a restart request
    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        init_done_d = init_done_q;
        if (restart) begin
            cnt_d = LOAD_CYC;
            busy_d = 1'b1;
            init_done_d = 1'b0;
        end else if (busy_q) begin
            if (cnt_q == 8'h01) begin
                busy_d = 1'b0;
                init_done_d = 1'b1;
            end
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_q <= LOAD_CYC;
            busy_q <= 1'b1;
            init_done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            init_done_q <= init_done_d;
        end
    end
endmodule // dsrh_autoload
`default_nettype wire

// *** verilog/dsrh_regs.sv ***
// serial target with own-address and soft-reset registers
`default_nettype none
`timescale 1ns/10ps
module dsrh_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // device pins
    input wire logic power_down_pin_n,
    input wire logic [6:0] strap_pin,
    // serial bus, open drain data
    input wire logic scl_pin,
    input wire logic sda_pin_in,
    output logic sda_pin_out,
    output logic sda_pin_oe,
    // to the rest of the device
    output logic [6:0] target_address_field,
    output logic logic_reset,
    output logic cfg_reset,
    output logic rom_load_busy,
    output logic init_done
);
    import dsrh_pkg::*;

    localparam logic [7:0] PULSE_CYC = 8'(DSRH_RST_PULSE_CYC);

    // ******************************************************************
    // pin synchronisers
    // ******************************************************************
    logic pdn_meta_q;
    logic pdn_sync_q;
    logic scl_meta_q;
    logic scl_s_q;
    logic scl_p_q;
    logic sda_meta_q;
    logic sda_s_q;
    logic sda_p_q;
    logic rst_n;

    // power-down pin is a reset too; its sync runs on nrst alone
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pdn_meta_q <= 1'b0;
            pdn_sync_q <= 1'b0;
        end else begin
            pdn_meta_q <= power_down_pin_n;
            pdn_sync_q <= pdn_meta_q;
        end
    end

    assign rst_n = nrst & pdn_sync_q;

    // bus lines: two stages, then a history stage for edges
    always_ff @(posedge core_clk) begin
        scl_meta_q <= scl_pin;
        scl_s_q <= scl_meta_q;
        scl_p_q <= scl_s_q;
        sda_meta_q <= sda_pin_in;
        sda_s_q <= sda_meta_q;
        sda_p_q <= sda_s_q;
    end

    logic scl_rise;
    logic scl_fall;
    logic start_evt;
    logic stop_evt;

    // start and stop are data edges while the clock stays high
    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;
    assign start_evt = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_evt = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // ******************************************************************
    // submodules
    // ******************************************************************
    logic [6:0] strap_addr;
    logic full_fire;
    logic reload_fire;

    dsrh_strap_sample dsrh_strap_sample_i (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .strap_pin(strap_pin),
        .recapture(full_fire),
        .strap_addr_q(strap_addr)
    );

    dsrh_autoload dsrh_autoload_i (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .restart(reload_fire),
        .busy_q(rom_load_busy),
        .init_done_q(init_done)
    );

    // ******************************************************************
    // serial target
    // ******************************************************************
    dsrh_i2c_state_type st_q;
    dsrh_i2c_state_type st_d;
    logic [2:0] bitcnt_q;
    logic [2:0] bitcnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic full_q;
    logic full_d;
    logic got_addr_q;
    logic got_addr_d;
    logic got_ptr_q;
    logic got_ptr_d;
    logic rd_q;
    logic rd_d;
    logic oe_q;
    logic oe_d;
    logic wr_en_q;
    logic wr_en_d;
    logic [7:0] wr_addr_q;
    logic [7:0] wr_addr_d;
    logic [7:0] wr_data_q;
    logic [7:0] wr_data_d;
    logic [7:0] rdata;

    // byte-wise target: address, pointer, then data with auto-increment
    always_comb begin
        st_d = st_q;
        bitcnt_d = bitcnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        full_d = full_q;
        got_addr_d = got_addr_q;
        got_ptr_d = got_ptr_q;
        rd_d = rd_q;
        oe_d = oe_q;
        wr_en_d = 1'b0;
        wr_addr_d = wr_addr_q;
        wr_data_d = wr_data_q;
        if (start_evt) begin
            st_d = DSRH_RECV;
            bitcnt_d = 3'h0;
            full_d = 1'b0;
            got_addr_d = 1'b0;
            got_ptr_d = 1'b0;
            oe_d = 1'b0;
        end else if (stop_evt) begin
            st_d = DSRH_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                DSRH_RECV: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_s_q};
                        bitcnt_d = bitcnt_q + 3'h1;
                        full_d = (bitcnt_q == 3'h7);
                    end else if (scl_fall && full_q) begin
                        full_d = 1'b0;
                        oe_d = 1'b1;
                        st_d = DSRH_ACK_OUT;
                        if (!got_addr_q) begin
                            // answer only the address in use
                            if (shift_q[7:1] == target_address_field) begin
                                got_addr_d = 1'b1;
                                rd_d = shift_q[0];
                            end else begin
                                oe_d = 1'b0;
                                st_d = DSRH_IGNORE;
                            end
                        end else if (!got_ptr_q) begin
                            got_ptr_d = 1'b1;
                            ptr_d = shift_q;
                        end else begin
                            wr_en_d = 1'b1;
                            wr_addr_d = ptr_q;
                            wr_data_d = shift_q;
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                DSRH_ACK_OUT: begin
                    if (scl_fall) begin
                        bitcnt_d = 3'h0;
                        if (rd_q) begin
                            tx_d = rdata;
                            ptr_d = ptr_q + 8'h01;
                            oe_d = ~rdata[7];
                            st_d = DSRH_SEND;
                        end else begin
                            oe_d = 1'b0;
                            st_d = DSRH_RECV;
                        end
                    end
                end
                DSRH_SEND: begin
                    if (scl_fall) begin
                        if (bitcnt_q == 3'h7) begin
                            oe_d = 1'b0;
                            full_d = 1'b0;
                            st_d = DSRH_ACK_IN;
                        end else begin
                            bitcnt_d = bitcnt_q + 3'h1;
                            tx_d = {tx_q[6:0], 1'b0};
                            oe_d = ~tx_q[6];
                        end
                    end
                end
                DSRH_ACK_IN: begin
                    // controller ack low means another byte is wanted
                    if (scl_rise) begin
                        if (sda_s_q) begin
                            st_d = DSRH_IGNORE;
                        end else begin
                            full_d = 1'b1;
                        end
                    end else if (scl_fall && full_q) begin
                        full_d = 1'b0;
                        bitcnt_d = 3'h0;
                        tx_d = rdata;
                        ptr_d = ptr_q + 8'h01;
                        oe_d = ~rdata[7];
                        st_d = DSRH_SEND;
                    end
                end
                DSRH_IDLE: begin
                    oe_d = 1'b0;
                end
                DSRH_IGNORE: begin
                    oe_d = 1'b0;
                end
                default: begin
                    st_d = DSRH_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q <= DSRH_IDLE;
            bitcnt_q <= 3'h0;
            shift_q <= DSRH_PTR_RST;
            tx_q <= DSRH_PTR_RST;
            ptr_q <= DSRH_PTR_RST;
            full_q <= 1'b0;
            got_addr_q <= 1'b0;
            got_ptr_q <= 1'b0;
            rd_q <= 1'b0;
            oe_q <= 1'b0;
            wr_en_q <= 1'b0;
            wr_addr_q <= DSRH_PTR_RST;
            wr_data_q <= DSRH_PTR_RST;
        end else begin
            st_q <= st_d;
            bitcnt_q <= bitcnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            full_q <= full_d;
            got_addr_q <= got_addr_d;
            got_ptr_q <= got_ptr_d;
            rd_q <= rd_d;
            oe_q <= oe_d;
            wr_en_q <= wr_en_d;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
        end
    end

    // open drain: the line is only ever pulled low
    assign sda_pin_oe = oe_q;
    assign sda_pin_out = 1'b0;

    // ******************************************************************
    // registers and soft resets
    // ******************************************************************
    logic ovr_q;
    logic ovr_d;
    logic [6:0] sw_addr_q;
    logic [6:0] sw_addr_d;
    logic [2:0] pend_q;
    logic [2:0] pend_d;
    logic [6:0] tgt_d;
    logic [7:0] lrst_cnt_q;
    logic [7:0] lrst_cnt_d;
    logic [7:0] crst_cnt_q;
    logic [7:0] crst_cnt_d;
    logic lrst_q;
    logic crst_q;
    logic fire;

    // resets wait for stop so the triggering write still gets its ack
    assign fire = stop_evt & (pend_q != DSRH_PEND_RST);
    assign full_fire = fire & pend_q[DSRH_FULL_RST_BIT];
    assign reload_fire = (fire & pend_q[DSRH_RELOAD_BIT]) | full_fire;

    // read mux; unmapped offsets and reserved bits read zero
    always_comb begin
        rdata = DSRH_RD_UNMAPPED;
        case (ptr_q)
            DSRH_OFS_ADDR: rdata = {target_address_field, ovr_q};
            DSRH_OFS_RST: rdata = {5'h00, pend_q};
            DSRH_OFS_STS: rdata[DSRH_INIT_DONE_BIT] = init_done;
            default: rdata = DSRH_RD_UNMAPPED;
        endcase
    end

    always_comb begin
        ovr_d = ovr_q;
        sw_addr_d = sw_addr_q;
        pend_d = pend_q;
        lrst_cnt_d = lrst_cnt_q;
        crst_cnt_d = crst_cnt_q;
        if (lrst_cnt_q != 8'h00) begin
            lrst_cnt_d = lrst_cnt_q - 8'h01;
        end
        if (crst_cnt_q != 8'h00) begin
            crst_cnt_d = crst_cnt_q - 8'h01;
        end
        // fired triggers clear themselves
        if (fire) begin
            pend_d = DSRH_PEND_RST;
            if (pend_q[DSRH_LOGIC_RST_BIT] || pend_q[DSRH_FULL_RST_BIT]) begin
                lrst_cnt_d = PULSE_CYC;
            end
        end
        if (full_fire) begin
            ovr_d = DSRH_OVR_RST;
            sw_addr_d = DSRH_SW_ADDR_RST;
            crst_cnt_d = PULSE_CYC;
        end
        if (wr_en_q && wr_addr_q == DSRH_OFS_ADDR) begin
            ovr_d = wr_data_q[DSRH_OVR_BIT];
            // field takes the write only with override selected
            if (wr_data_q[DSRH_OVR_BIT]) begin
                sw_addr_d = wr_data_q[DSRH_ADDR_MSB:DSRH_ADDR_LSB];
            end
        end
        // write one to set, zero has no effect, upper bits dropped
        if (wr_en_q && wr_addr_q == DSRH_OFS_RST) begin
            pend_d = pend_d | wr_data_q[2:0];
        end
    end

    // address in use: strap unless override selected
    assign tgt_d = ovr_d ? sw_addr_d : strap_addr;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ovr_q <= DSRH_OVR_RST;
            sw_addr_q <= DSRH_SW_ADDR_RST;
            pend_q <= DSRH_PEND_RST;
            lrst_cnt_q <= 8'h00;
            crst_cnt_q <= 8'h00;
            lrst_q <= 1'b0;
            crst_q <= 1'b0;
            target_address_field <= DSRH_SW_ADDR_RST;
        end else begin
            ovr_q <= ovr_d;
            sw_addr_q <= sw_addr_d;
            pend_q <= pend_d;
            lrst_cnt_q <= lrst_cnt_d;
            crst_cnt_q <= crst_cnt_d;
            lrst_q <= (lrst_cnt_d != 8'h00);
            crst_q <= (crst_cnt_d != 8'h00);
            target_address_field <= tgt_d;
        end
    end

    assign logic_reset = lrst_q;
    assign cfg_reset = crst_q;
endmodule // dsrh_regs
`default_nettype wire

// *** test/dsrh_regs_sva.sv ***
// checker for the own-address and soft-reset register pair
`default_nettype none
`timescale 1ns/10ps
module dsrh_regs_sva (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // pins
    input wire logic power_down_pin_n,
    input wire logic [6:0] strap_pin,
    input wire logic scl_pin,
    // device side
    input wire logic sda_pin_oe,
    input wire logic [6:0] target_address_field,
    input wire logic logic_reset,
    input wire logic cfg_reset,
    input wire logic rom_load_busy,
    input wire logic init_done
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // ****************************************************************
    // soft reset pulses
    // ****************************************************************
    a_logic_pulse_len: assert property ($rose(logic_reset) |->
        logic_reset [*5] ##1 !logic_reset) else $error("logic pulse");
    a_cfg_pulse_len: assert property ($rose(cfg_reset) |->
        cfg_reset [*5] ##1 !cfg_reset) else $error("cfg pulse");
    a_cfg_implies_logic: assert property (cfg_reset |->
        logic_reset) else $error("cfg without logic reset");
    // soft resets fire only at a stop, with the bus clock high
    a_fire_at_stop: assert property ($rose(logic_reset) |->
        scl_pin) else $error("reset fired mid-frame");
    a_full_reverts: assert property ($rose(cfg_reset) |->
        ##[1:8] target_address_field == strap_pin)
        else $error("address not back to strap");
    // pin reset lands after its two-flop sync
    a_pin_clears: assert property (!power_down_pin_n [*5] |->
        ##1 (!logic_reset && !cfg_reset && !init_done && !sda_pin_oe))
        else $error("power-down pin did not reset");

    // ****************************************************************
    // rom load status
    // ****************************************************************
    a_done_at_end: assert property ($fell(rom_load_busy) |->
        $rose(init_done)) else $error("done not set at load end");
    a_reload_drops: assert property ($rose(rom_load_busy) |=>
        !init_done) else $error("done kept during reload");
    a_drop_needs_load: assert property ($fell(init_done) |->
        rom_load_busy) else $error("done fell without load");
endmodule // dsrh_regs_sva
`default_nettype wire

// *** test/dsrh_i2c_host.sv ***
// behavioural serial bus controller driving the register pair
`default_nettype none
`timescale 1ns/10ps
module dsrh_i2c_host (
    // clock
    input wire logic core_clk,
    // bus lines, data is open drain with pull-up
    output logic scl_pin,
    output logic sda_drive,
    input wire logic sda_line
);
    initial begin
        scl_pin = 1'b1;
        sda_drive = 1'b0;
    end

    // half period of 6 cycles keeps above the 4 cycle minimum
    task automatic half();
        repeat (6) @(posedge core_clk);
        #1;
    endtask

    // data moves a half after the clock falls, never with it
    task automatic bit_cycle(input logic b, output logic s);
        sda_drive = !b;
        half();
        scl_pin = 1'b1;
        half();
        s = sda_line;
        scl_pin = 1'b0;
        half();
    endtask

    // also serves as repeated start from a low clock
    task automatic go_start();
        sda_drive = 1'b0;
        half();
        scl_pin = 1'b1;
        half();
        sda_drive = 1'b1;
        half();
        scl_pin = 1'b0;
        half();
    endtask

    task automatic go_stop();
        sda_drive = 1'b1;
        half();
        scl_pin = 1'b1;
        half();
        sda_drive = 1'b0;
        half();
    endtask

    // msb first, ninth bit released for the acknowledge
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
        end
        bit_cycle(1'b1, s);
        ack = !s;
    endtask

    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d[i]);
        end
        bit_cycle(last, s);
    endtask
endmodule // dsrh_i2c_host
`default_nettype wire

// *** test/dsrh_regs_bench.sv ***
// self-checking bench for the own-address and soft-reset registers
`default_nettype none
`timescale 1ns/10ps
module dsrh_regs_bench;
    import dsrh_pkg::*;
    localparam logic [6:0] STRAP_ADDR = 7'h3A;
    localparam logic [6:0] SOFT_ADDR = 7'h55;
    logic core_clk;
    logic nrst;
    logic power_down_pin_n;
    logic [6:0] strap_pin;
    wire logic scl_pin;
    wire logic host_drive;
    logic sda_pin_out;
    logic sda_pin_oe;
    logic [6:0] target_address_field;
    logic logic_reset;
    logic cfg_reset;
    logic rom_load_busy;
    logic init_done;
    logic ack;
    logic [7:0] sts;
    logic [7:0] lr_n = 8'h00;
    logic [7:0] cr_n = 8'h00;
    int bad_count = 0;
    int total_checks = 0;
    // pull-up: low while either party pulls, device pulls only a low
    wire logic sda_line = !(host_drive || (sda_pin_oe && !sda_pin_out));

    dsrh_regs dsrh_regs_i (.core_clk(core_clk), .nrst(nrst),
        .power_down_pin_n(power_down_pin_n), .strap_pin(strap_pin),
        .scl_pin(scl_pin), .sda_pin_in(sda_line),
        .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe),
        .target_address_field(target_address_field),
        .logic_reset(logic_reset), .cfg_reset(cfg_reset),
        .rom_load_busy(rom_load_busy), .init_done(init_done));
    dsrh_i2c_host dsrh_i2c_host_i (.core_clk(core_clk),
        .scl_pin(scl_pin), .sda_drive(host_drive), .sda_line(sda_line));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge logic_reset) lr_n <= lr_n + 8'h01;
    always @(posedge cfg_reset) cr_n <= cr_n + 8'h01;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [6:0] a, input logic [7:0] ofs,
                             input logic [7:0] d);
        logic k0, k1, k2;
        dsrh_i2c_host_i.go_start();
        dsrh_i2c_host_i.put_byte({a, 1'b0}, k0);
        dsrh_i2c_host_i.put_byte(ofs, k1);
        dsrh_i2c_host_i.put_byte(d, k2);
        dsrh_i2c_host_i.go_stop();
        check({5'h00, k0, k1, k2}, 8'h07);
    endtask

    // pointer write, repeated start, one byte read with nack
    task automatic reg_get(input logic [6:0] a, input logic [7:0] ofs,
                           output logic [7:0] d);
        logic k0, k1, k2;
        dsrh_i2c_host_i.go_start();
        dsrh_i2c_host_i.put_byte({a, 1'b0}, k0);
        dsrh_i2c_host_i.put_byte(ofs, k1);
        dsrh_i2c_host_i.go_start();
        dsrh_i2c_host_i.put_byte({a, 1'b1}, k2);
        dsrh_i2c_host_i.get_byte(1'b1, d);
        dsrh_i2c_host_i.go_stop();
        check({5'h00, k0, k1, k2}, 8'h07);
    endtask

    task automatic reg_read(input logic [6:0] a, input logic [7:0] ofs,
                            input logic [7:0] exp);
        logic [7:0] d;
        reg_get(a, ofs, d);
        check(d, exp);
    endtask

    task automatic complete_run();
        if (bad_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog, about seven times the expected run
    initial begin
        repeat (80000) @(posedge core_clk);
        bad_count++;
        complete_run();
    end

    initial begin
        nrst = 1'b0;
        power_down_pin_n = 1'b1;
        strap_pin = STRAP_ADDR;
        repeat (8) @(posedge core_clk);
        #1 nrst = 1'b1;
        repeat (60) @(posedge core_clk);
        check({7'h00, init_done}, 8'h01);
        reg_read(STRAP_ADDR, DSRH_OFS_STS, 8'h40);
        reg_read(STRAP_ADDR, DSRH_OFS_ADDR, {STRAP_ADDR, 1'b0});
        reg_read(STRAP_ADDR, DSRH_OFS_RST, 8'h00);
        reg_read(STRAP_ADDR, 8'h07, 8'h00);
        // field write without override is dropped
        reg_write(STRAP_ADDR, DSRH_OFS_ADDR, {SOFT_ADDR, 1'b0});
        reg_read(STRAP_ADDR, DSRH_OFS_ADDR, {STRAP_ADDR, 1'b0});
        reg_write(STRAP_ADDR, DSRH_OFS_ADDR, {SOFT_ADDR, 1'b1});
        check({1'b0, target_address_field}, {1'b0, SOFT_ADDR});
        reg_read(SOFT_ADDR, DSRH_OFS_ADDR, {SOFT_ADDR, 1'b1});
        // old strapped address must now go unanswered
        dsrh_i2c_host_i.go_start();
        dsrh_i2c_host_i.put_byte({STRAP_ADDR, 1'b0}, ack);
        dsrh_i2c_host_i.go_stop();
        check({7'h00, ack}, 8'h00);
        // logic-only reset keeps config; reserved bits set too
        reg_write(SOFT_ADDR, DSRH_OFS_RST, 8'hF9);
        repeat (8) @(posedge core_clk);
        check(lr_n, 8'h01);
        check(cr_n, 8'h00);
        reg_read(SOFT_ADDR, DSRH_OFS_ADDR, {SOFT_ADDR, 1'b1});
        reg_read(SOFT_ADDR, DSRH_OFS_RST, 8'h00);
        // reload, then poll the status flag
        reg_write(SOFT_ADDR, DSRH_OFS_RST, 8'h04);
        check({6'h00, rom_load_busy, init_done}, 8'h02);
        sts = 8'h00;
        for (int n = 0; n < 8 && sts[6] !== 1'b1; n++) begin
            reg_get(SOFT_ADDR, DSRH_OFS_STS, sts);
        end
        check(sts, 8'h40);
        // power-down pin brings back the strap address
        power_down_pin_n = 1'b0;
        repeat (6) @(posedge core_clk);
        #1 power_down_pin_n = 1'b1;
        repeat (60) @(posedge core_clk);
        check({1'b0, target_address_field}, {1'b0, STRAP_ADDR});
        // full reset drops the override
        reg_write(STRAP_ADDR, DSRH_OFS_ADDR, {SOFT_ADDR, 1'b1});
        reg_write(SOFT_ADDR, DSRH_OFS_RST, 8'h02);
        repeat (8) @(posedge core_clk);
        check(lr_n, 8'h02);
        check(cr_n, 8'h01);
        reg_read(STRAP_ADDR, DSRH_OFS_ADDR, {STRAP_ADDR, 1'b0});
        reg_write(STRAP_ADDR, DSRH_OFS_RST, 8'h00);
        repeat (8) @(posedge core_clk);
        check(lr_n, 8'h02);
        complete_run();
    end
endmodule // dsrh_regs_bench

bind dsrh_regs dsrh_regs_sva dsrh_regs_sva_i (.core_clk(core_clk),
    .nrst(nrst), .power_down_pin_n(power_down_pin_n),
    .strap_pin(strap_pin), .scl_pin(scl_pin), .sda_pin_oe(sda_pin_oe),
    .target_address_field(target_address_field),
    .logic_reset(logic_reset), .cfg_reset(cfg_reset),
    .rom_load_busy(rom_load_busy), .init_done(init_done));
`default_nettype wire
